//--- hw/cbt_pkg.sv
// Package with register map, field layout and reset constants for the CAN bit timing and capture block.
// Summary of operation
// (RL1) On arbitration loss capture the bit position and raise the enabled interrupt.
// (RL2) Captured position holds until software reads it; that read re-arms capture.
// (RL3) Position register bits 7 to 5 always read as zero.
// (RL4) Codes 0 to 10 mean loss in identifier bits 28 down to 18.
// (RL5) Code 11 means loss in the SRTR bit, code 12 in the IDE bit.
// (RL6) Codes 13 to 30 mean loss in identifier bits 17 down to 0, extended only.
// (RL7) Code 31 means arbitration lost in the RTR bit.
// (RL8) Timing register 0 bits 7 to 6 hold the resynchronisation jump width.
// (RL9) Time quantum is two oscillator periods times prescaler plus one.
// (RL10) Sampling bit set samples the bus three times per bit, clear once.
// (RL11) Bit is one sync quantum, segment one plus one, segment two plus one.
// (RL12) Hardware reset loads the clock divider register with 8'hC0.
// (RL13) Software reset leaves the clock divider register unchanged.
// (RL14) Divider codes 0 to 6 give oscillator over 2 to 14; code 7 undivided.
// (RL15) Divider field is writable in reset mode and operating mode alike.
// (RL16) Setting the clock-off bit disables the clock output.
// (RL17) Arbitration-lost flag sets on a loss only when its enable bit is set.
// (RL18) Both timing registers are writable in reset mode only, read-only otherwise.
// (RL19) Divider register bits 7 to 4 are fixed at 1100 and read back so.
`default_nettype none
package cbt_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [5:0] CBT_IDX_MODE = 6'h00;
   localparam logic [5:0] CBT_IDX_STATUS = 6'h03;
   localparam logic [5:0] CBT_IDX_ENABLE = 6'h04;
   localparam logic [5:0] CBT_IDX_TIMING0 = 6'h06;
   localparam logic [5:0] CBT_IDX_TIMING1 = 6'h07;
   localparam logic [5:0] CBT_IDX_POSN = 6'h0B;
   localparam logic [5:0] CBT_IDX_DIV = 6'h1F;
   // Field positions.
   localparam int CBT_MODE_RESET_BIT = 0;
   localparam int CBT_MODE_SOFT_BIT = 1;
   localparam int CBT_FLAG_ARB_BIT = 6;
   localparam int CBT_DIV_OFF_BIT = 3;
   // Values after reset and fixed patterns.
   localparam logic [7:0] CBT_DIV_RESET = 8'hC0;
   localparam logic [3:0] CBT_DIV_FIXED = 4'hC;
   localparam logic [2:0] CBT_SEL_UNDIVIDED = 3'h7;
   localparam logic [7:0] CBT_TIMING_RESET = 8'h00;
   localparam logic MODE_RESET_INIT = 1'b1;
   // Counts of cycles.
   localparam int CBT_TQ_MULT = 2;
   localparam logic [4:0] CBT_TRIPLE_SPAN = 5'h02;
   // AXI responses.
   localparam logic [1:0] CBT_RESP_OKAY = 2'h0;
   localparam logic [1:0] CBT_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] jump_width;
      logic [5:0] quantum_prescaler;
   } cbt_prescale_jump_s;

   typedef struct packed {
      logic triple_sample_select;
      logic [2:0] segment_two_length;
      logic [3:0] segment_one_length;
   } cbt_segments_s;

   typedef enum logic [1:0] {
      CBT_PH_SYNC = 2'b00,
      CBT_PH_SEG1 = 2'b01,
      CBT_PH_SEG2 = 2'b10
   } cbt_phase_e;
endpackage
`default_nettype wire

//--- hw/cbt_core.sv
// CAN bit timing, arbitration-loss capture and clock output divider behind an AXI4-Lite slave.
//
// Our own choice: the AXI4-Lite interface to the registers.
`default_nettype none
module cbt_core
   import cbt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic arb_lost,
   input wire logic [4:0] arb_position,
   input wire logic bus_rx,
   output logic reset_mode,
   output logic irq,
   output logic tq_tick,
   output logic bit_start,
   output logic sample_point,
   output logic sampled_bit,
   output logic clock_output_pin
);
   // Register state.
   cbt_prescale_jump_s timing0;
   cbt_segments_s timing1;
   logic [4:0] posn_code;
   logic posn_locked;
   logic [7:0] flags;
   logic [7:0] enables;
   logic [3:0] divider_low;

   // Bus handshake decode; both write channels are taken together once no response is pending.
   wire logic wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire logic rd_take = s_axi_arvalid & ~s_axi_rvalid;
   wire logic [5:0] wr_idx = s_axi_awaddr[7:2];
   wire logic [5:0] rd_idx = s_axi_araddr[7:2];
   wire logic wr_lane = wr_take & s_axi_wstrb[0];
   wire logic [7:0] wbyte = s_axi_wdata[7:0];
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign s_axi_arready = ~s_axi_rvalid;

   // Write targets; the timing registers only accept writes while the controller is in reset mode.
   wire logic wr_mode = wr_lane & (wr_idx == CBT_IDX_MODE);
   wire logic wr_enable = wr_lane & (wr_idx == CBT_IDX_ENABLE);
   wire logic wr_timing0 = wr_lane & (wr_idx == CBT_IDX_TIMING0) & reset_mode; // RL18
   wire logic wr_timing1 = wr_lane & (wr_idx == CBT_IDX_TIMING1) & reset_mode; // RL18
   wire logic wr_divider = wr_lane & (wr_idx == CBT_IDX_DIV); // RL15
   wire logic soft_reset = wr_mode & wbyte[CBT_MODE_SOFT_BIT];
   wire logic wr_known = (wr_idx == CBT_IDX_MODE) | (wr_idx == CBT_IDX_STATUS) | (wr_idx == CBT_IDX_ENABLE) |
      (wr_idx == CBT_IDX_TIMING0) | (wr_idx == CBT_IDX_TIMING1) | (wr_idx == CBT_IDX_POSN) | (wr_idx == CBT_IDX_DIV);

   // Reads with side effects: the position read re-arms capture, the status read clears flags.
   wire logic rd_posn = rd_take & (rd_idx == CBT_IDX_POSN);
   wire logic rd_status = rd_take & (rd_idx == CBT_IDX_STATUS);

   // Read data mux; unmapped indices answer zero with an error response.
   logic [7:0] rd_byte;
   logic rd_known;
   always_comb begin
      rd_known = 1'b1;
      case (rd_idx)
         CBT_IDX_MODE: rd_byte = {7'h00, reset_mode};
         CBT_IDX_STATUS: rd_byte = flags;
         CBT_IDX_ENABLE: rd_byte = enables;
         CBT_IDX_TIMING0: rd_byte = timing0;
         CBT_IDX_TIMING1: rd_byte = timing1;
         CBT_IDX_POSN: rd_byte = {3'h0, posn_code}; // RL3
         CBT_IDX_DIV: rd_byte = {CBT_DIV_FIXED, divider_low}; // RL19
         default: begin
            rd_byte = 8'h00;
            rd_known = 1'b0;
         end
      endcase
   end

   // Write response channel.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CBT_RESP_OKAY;
      end else if (wr_take) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_known ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read data channel.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= CBT_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= rd_known ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Mode register; a soft reset forces reset mode but spares the divider.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_mode <= MODE_RESET_INIT;
      end else if (wr_mode) begin
         reset_mode <= wbyte[CBT_MODE_RESET_BIT] | wbyte[CBT_MODE_SOFT_BIT];
      end
   end

   // Bit timing registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timing0 <= CBT_TIMING_RESET;
         timing1 <= CBT_TIMING_RESET;
      end else begin
         if (wr_timing0) begin
            timing0 <= wbyte; // RL8
         end
         if (wr_timing1) begin
            timing1 <= wbyte;
         end
      end
   end

   // Clock divider register: only the hardware reset reloads it, never the soft reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         divider_low <= CBT_DIV_RESET[3:0]; // RL12
      end else if (wr_divider) begin
         divider_low <= wbyte[3:0]; // RL13
      end
   end

   // Capture: a loss in the same cycle as the re-arming read wins and is caught.
   wire logic capture = arb_lost & (~posn_locked | rd_posn);
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_reset) begin
         posn_code <= 5'h00;
         posn_locked <= 1'b0;
      end else if (capture) begin
         posn_code <= arb_position; // RL1 RL4 RL5 RL6 RL7
         posn_locked <= 1'b1;
      end else if (rd_posn) begin
         posn_locked <= 1'b0; // RL2
      end
   end

   // Sticky flags cleared by a status read; a new event in the read cycle still sets.
   wire logic [7:0] flag_set = {1'b0, arb_lost & enables[CBT_FLAG_ARB_BIT], 6'h00}; // RL17
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_reset) begin
         flags <= 8'h00;
      end else begin
         flags <= (rd_status ? 8'h00 : flags) | flag_set; // RL1
      end
   end

   // Enable register doubles as the interrupt mask.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enables <= 8'h00;
      end else if (wr_enable) begin
         enables <= wbyte;
      end
   end
   assign irq = |(flags & enables);

   // Clock output divider; the oscillator is aclk, so code 7 routes aclk itself.
   logic [2:0] div_cnt;
   logic div_q;
   wire logic [2:0] div_sel = divider_low[2:0];
   wire logic clock_off = divider_low[CBT_DIV_OFF_BIT];
   wire logic div_flip = (div_cnt >= div_sel);
   always_ff @(posedge aclk) begin
      if (!aresetn || clock_off || div_sel == CBT_SEL_UNDIVIDED) begin
         div_cnt <= 3'h0;
         div_q <= 1'b0;
      end else begin
         div_cnt <= div_flip ? 3'h0 : div_cnt + 3'h1;
         div_q <= div_flip ? ~div_q : div_q; // RL14
      end
   end
   // Undivided mode passes the clock net straight through, which costs a glitch-free guarantee on changes.
   assign clock_output_pin = ~clock_off & ((div_sel == CBT_SEL_UNDIVIDED) ? aclk : div_q); // RL16

   // Bus input synchroniser; the third stage only serves the edge detector.
   logic rx_meta;
   logic rx_sync;
   logic rx_prev;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_meta <= bus_rx;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end
   wire logic rx_fall = rx_prev & ~rx_sync;

   // Time quantum prescaler: one tick every two times (prescaler plus one) oscillator cycles.
   logic [6:0] tq_cnt;
   wire logic [6:0] tq_last = 7'((CBT_TQ_MULT * (int'(timing0.quantum_prescaler) + 1)) - 1); // RL9
   always_ff @(posedge aclk) begin
      if (!aresetn || reset_mode) begin
         tq_cnt <= 7'h00;
      end else begin
         tq_cnt <= (tq_cnt == tq_last) ? 7'h00 : tq_cnt + 7'h01;
      end
   end
   assign tq_tick = ~reset_mode & (tq_cnt == tq_last);

   // Bit segment sequencer with one resynchronisation per bit.
   cbt_phase_e phase;
   cbt_phase_e next_phase;
   logic [4:0] qcnt;
   logic [4:0] next_qcnt;
   logic [4:0] seg1_end;
   logic [4:0] next_seg1_end;
   logic edge_seen;
   logic resynced;
   logic [2:0] samples;
   wire logic [4:0] jump = {3'h0, timing0.jump_width} + 5'h01; // RL8
   wire logic [4:0] seg2_end = {2'h0, timing1.segment_two_length};
   wire logic [4:0] lengthen = (qcnt + 5'h01 < jump) ? qcnt + 5'h01 : jump;
   wire logic do_resync = edge_seen & ~resynced;
   wire logic seg2_cut = (seg2_end - qcnt) < jump;
   wire logic in_sample_window = timing1.triple_sample_select ? (seg1_end - qcnt <= CBT_TRIPLE_SPAN)
      : (qcnt == seg1_end); // RL10

   always_comb begin
      next_phase = phase;
      next_qcnt = qcnt + 5'h01;
      next_seg1_end = seg1_end;
      case (phase)
         CBT_PH_SYNC: begin
            next_phase = CBT_PH_SEG1;
            next_qcnt = 5'h00;
            next_seg1_end = {1'b0, timing1.segment_one_length}; // RL11
         end
         CBT_PH_SEG1: begin
            if (do_resync) begin
               next_seg1_end = seg1_end + lengthen;
            end
            if (qcnt == seg1_end && !do_resync) begin
               next_phase = CBT_PH_SEG2;
               next_qcnt = 5'h00;
            end
         end
         CBT_PH_SEG2: begin
            if (do_resync && seg2_cut) begin
               next_phase = CBT_PH_SYNC;
            end else if (do_resync) begin
               next_qcnt = qcnt + jump;
            end else if (qcnt == seg2_end) begin
               next_phase = CBT_PH_SYNC; // RL11
            end
         end
         default: begin
            next_phase = CBT_PH_SYNC;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || reset_mode) begin
         phase <= CBT_PH_SYNC;
         qcnt <= 5'h00;
         seg1_end <= 5'h00;
      end else if (tq_tick) begin
         phase <= next_phase;
         qcnt <= next_qcnt;
         seg1_end <= next_seg1_end;
      end
   end

   // An edge is remembered until the next quantum; only one resync is spent per bit.
   always_ff @(posedge aclk) begin
      if (!aresetn || reset_mode) begin
         edge_seen <= 1'b0;
         resynced <= 1'b0;
      end else begin
         edge_seen <= tq_tick ? rx_fall : (edge_seen | rx_fall);
         if (tq_tick && phase == CBT_PH_SYNC) begin
            resynced <= 1'b0;
         end else if (tq_tick && do_resync && phase != CBT_PH_SYNC) begin
            resynced <= 1'b1;
         end
      end
   end

   // Sampling strobes; with triple sampling the last three quanta of segment one are voted.
   wire logic sample_tick = tq_tick & (phase == CBT_PH_SEG1) & in_sample_window;
   wire logic sp_tick = tq_tick & (phase == CBT_PH_SEG1) & (qcnt == seg1_end) & ~do_resync;
   wire logic [2:0] next_samples = sample_tick ? {samples[1:0], rx_sync} : samples;
   wire logic vote = timing1.triple_sample_select ? ((next_samples[0] & next_samples[1]) |
      (next_samples[1] & next_samples[2]) | (next_samples[0] & next_samples[2])) : next_samples[0]; // RL10
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         samples <= 3'h7;
         sampled_bit <= 1'b1;
         sample_point <= 1'b0;
         bit_start <= 1'b0;
      end else begin
         samples <= next_samples;
         sampled_bit <= sp_tick ? vote : sampled_bit;
         sample_point <= sp_tick;
         bit_start <= tq_tick & (phase == CBT_PH_SYNC);
      end
   end

   // Checks.
   logic [7:0] tq_gap;
   logic tq_gap_ok;
   logic [5:0] bit_q;
   logic bit_ok;
   logic bit_clean;
   logic [3:0] half_cnt;
   logic half_ok;
   always_ff @(posedge aclk) begin
      if (!aresetn || reset_mode) begin
         tq_gap <= 8'h00;
         tq_gap_ok <= 1'b0;
         bit_q <= 6'h00;
         bit_ok <= 1'b0;
         bit_clean <= 1'b1;
      end else begin
         tq_gap <= tq_tick ? 8'h00 : tq_gap + 8'h01;
         tq_gap_ok <= tq_gap_ok | tq_tick;
         bit_q <= bit_start ? 6'h00 : (tq_tick ? bit_q + 6'h01 : bit_q);
         bit_ok <= bit_ok | bit_start;
         bit_clean <= bit_start ? 1'b1 : (bit_clean & ~(tq_tick & do_resync));
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || clock_off || div_sel == CBT_SEL_UNDIVIDED || wr_divider) begin
         half_cnt <= 4'h0;
         half_ok <= 1'b0;
      end else begin
         half_cnt <= div_flip ? 4'h0 : half_cnt + 4'h1;
         half_ok <= half_ok | div_flip;
      end
   end
   sequence s_loss_taken;
      arb_lost && !posn_locked && aresetn && !soft_reset;
   endsequence
   sequence s_held_unread;
      posn_locked && !rd_posn && !soft_reset;
   endsequence
   chk_posn_capture: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
      s_loss_taken |=> posn_locked && posn_code == $past(arb_position)) else $error("position not captured");
   chk_posn_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
      s_held_unread |=> $stable(posn_code) && posn_locked) else $error("position changed before read");
   chk_posn_rearm: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
      rd_posn && !arb_lost && !soft_reset |=> !posn_locked) else $error("capture not re-armed");
   chk_posn_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      rd_posn |=> s_axi_rvalid && s_axi_rdata == {27'h0, $past(posn_code)}) else $error("bad position data");
   chk_flag_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RL17
      $rose(flags[CBT_FLAG_ARB_BIT]) |-> $past(arb_lost && enables[CBT_FLAG_ARB_BIT])) else $error("stray flag");
   chk_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // RL17
      arb_lost && enables[CBT_FLAG_ARB_BIT] && !soft_reset |=> flags[CBT_FLAG_ARB_BIT] ##0 irq)
      else $error("enabled arbitration loss not flagged");
   chk_timing_locked: assert property (@(posedge aclk) disable iff (!aresetn) // RL18
      !reset_mode |=> $stable(timing0) && $stable(timing1)) else $error("timing changed in operating mode");
   chk_tq_spacing: assert property (@(posedge aclk) disable iff (!aresetn || reset_mode) // RL9
      tq_tick && tq_gap_ok |-> 32'(tq_gap) + 1 == CBT_TQ_MULT * (32'(timing0.quantum_prescaler) + 1))
      else $error("time quantum length wrong");
   chk_bit_length: assert property (@(posedge aclk) disable iff (!aresetn || reset_mode) // RL11
      bit_start && bit_ok && $past(bit_clean) |-> 32'(bit_q) == 3 + 32'(timing1.segment_one_length)
      + 32'(timing1.segment_two_length)) else $error("bit period length wrong");
   chk_divider_reset: assert property (@(posedge aclk) // RL12
      !$past(aresetn) && aresetn |-> {CBT_DIV_FIXED, divider_low} == CBT_DIV_RESET) else $error("bad divider reset");
   chk_divider_soft: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
      soft_reset && !wr_divider |=> $stable(divider_low)) else $error("soft reset hit divider");
   chk_div_period: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
      div_flip && half_ok && !clock_off && div_sel != CBT_SEL_UNDIVIDED |-> half_cnt == {1'b0, div_sel})
      else $error("clock divider half period wrong");
   chk_clock_output_pin_off: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
      clock_off |-> !clock_output_pin ##1 (clock_off -> !div_q)) else $error("clock output while off");
endmodule
`default_nettype wire

//--- tb/cbt_can_node.sv
// Behavioural model of the other nodes on the CAN bus, seen through the receive line.
`default_nettype none
module cbt_can_node (
   input wire logic dominant,
   output logic bus_rx
);
   timeunit 1ns;
   timeprecision 1ns;
   // The bus idles recessive; any node asking for dominant pulls the wired line low.
   assign bus_rx = ~dominant;
endmodule
`default_nettype wire

//--- tb/test_can_bit_timing_arb_capture.sv
// Self-checking testbench for the CAN bit timing and arbitration capture block.
`default_nettype none
module test_can_bit_timing_arb_capture;
   import cbt_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, arb_lost = 1'b0, dominant = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic [4:0] arb_position = 5'h00;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_rx, reset_mode, irq;
   logic tq_tick, bit_start, sample_point, sampled_bit, clock_output_pin;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, data;
   logic [4:0] codes [7] = '{5'h00, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h1E, 5'h1F};
   int fails = 0, checks_done = 0, n;

   cbt_core i_cbt_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .arb_lost(arb_lost), .arb_position(arb_position), .bus_rx(bus_rx), .reset_mode(reset_mode), .irq(irq),
      .tq_tick(tq_tick), .bit_start(bit_start), .sample_point(sample_point), .sampled_bit(sampled_bit),
      .clock_output_pin(clock_output_pin));
   cbt_can_node i_cbt_can_node (.dominant(dominant), .bus_rx(bus_rx));

   // Free-running 125 MHz clock.
   initial begin
      forever #4 aclk = ~aclk;
   end

   // Compares one value and counts it; a four-state mismatch never passes.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Bus write; address and data are offered together and held until both are taken.
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask

   // Bus read; data and response are taken at the edge where rvalid is seen.
   task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rchk(input string what, input logic [5:0] idx, input logic [7:0] exp);
      rd(idx, data, resp);
      chk(what, data, {24'h0, exp});
   endtask

   // One-cycle loss pulse; the position lines change afterwards so a stale sample shows.
   task automatic lose(input logic [4:0] p);
      @(posedge aclk);
      arb_lost <= 1'b1;
      arb_position <= p;
      @(posedge aclk);
      arb_lost <= 1'b0;
      arb_position <= ~p;
      #1;
   endtask

   function automatic logic sig(input int w);
      return (w == 0) ? tq_tick : (w == 1) ? bit_start : clock_output_pin;
   endfunction

   // Cycles from one rising sample of the chosen signal to the next.
   // Waits for a low sample first so that counting starts on a true rising sample.
   task automatic gap(input int w, output int cnt);
      do @(posedge aclk); while (sig(w) !== 1'b0);
      do @(posedge aclk); while (sig(w) !== 1'b1);
      cnt = 0;
      do begin @(posedge aclk); cnt++; end while (sig(w) !== 1'b0);
      do begin @(posedge aclk); cnt++; end while (sig(w) !== 1'b1);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Cuts a hang short; the whole sequence needs well under 5000 cycles.
   initial begin
      #(8 * 20000);
      fails++;
      tally_and_finish();
   end

   // Main sequence.
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rchk("divider reset", CBT_IDX_DIV, CBT_DIV_RESET);
      rchk("timing0 reset", CBT_IDX_TIMING0, 8'h00);
      wr(CBT_IDX_TIMING0, 8'h01);
      wr(CBT_IDX_TIMING1, 8'h92);
      rchk("timing0", CBT_IDX_TIMING0, 8'h01);
      rchk("timing1", CBT_IDX_TIMING1, 8'h92);
      wr(CBT_IDX_MODE, 8'h00);
      wr(CBT_IDX_TIMING0, 8'hFF);
      rchk("timing0 locked", CBT_IDX_TIMING0, 8'h01);
      $display("test registers done");
      gap(0, n);
      chk("quantum cycles", n, 4);
      gap(1, n);
      chk("bit cycles", n, 24);
      dominant <= 1'b1;
      repeat (2) do @(posedge aclk); while (sample_point !== 1'b1);
      #1 chk("sampled bit", sampled_bit, 1'b0);
      dominant <= 1'b0;
      $display("test timing done");
      for (int c = 0; c < 7; c++) begin
         wr(CBT_IDX_DIV, c[7:0]);
         gap(2, n);
         chk("clock out period", n, 2 * (c + 1));
      end
      rchk("divider fixed", CBT_IDX_DIV, 8'hC6);
      wr(CBT_IDX_DIV, 8'h08);
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 6; i++) begin
         @(posedge aclk);
         #1 chk("clock off", clock_output_pin, 1'b0);
      end
      wr(CBT_IDX_DIV, 8'h07);
      @(posedge aclk);
      #1 chk("undivided high", clock_output_pin, 1'b1);
      @(negedge aclk);
      #1 chk("undivided low", clock_output_pin, 1'b0);
      $display("test divider done");
      wr(CBT_IDX_ENABLE, 8'h40);
      foreach (codes[i]) begin
         lose(codes[i]);
         chk("irq raised", irq, 1'b1);
         rchk("position", CBT_IDX_POSN, {3'b000, codes[i]});
         rchk("flag", CBT_IDX_STATUS, 8'h40);
         #1 chk("irq cleared", irq, 1'b0);
      end
      lose(5'h03);
      lose(5'h1C);
      rchk("held position", CBT_IDX_POSN, 8'h03);
      lose(5'h1A);
      rchk("rearmed position", CBT_IDX_POSN, 8'h1A);
      rchk("flag", CBT_IDX_STATUS, 8'h40);
      wr(CBT_IDX_ENABLE, 8'h00);
      lose(5'h07);
      chk("masked irq", irq, 1'b0);
      rchk("masked flag", CBT_IDX_STATUS, 8'h00);
      rchk("masked position", CBT_IDX_POSN, 8'h07);
      $display("test capture done");
      wr(CBT_IDX_DIV, 8'h05);
      wr(CBT_IDX_MODE, 8'h02);
      rchk("divider kept", CBT_IDX_DIV, 8'hC5);
      rchk("mode", CBT_IDX_MODE, 8'h01);
      rd(6'h05, data, resp);
      chk("unmapped response", resp, CBT_RESP_SLVERR);
      $display("test soft reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
